// *** logic/sfr_bank_defs.vh ***
// Behaviour
// - reset makes ports 0 and 1 input-only, pull-ups off; port 3 bits 7:2 come up quasi with pull-ups on
// - each pin has its own mode bits
// - port one bit five never drives
// - low reset pin resets all but the reset source flags, flash command byte, FD bit value latch and programming entry
// - reset pin sampled at power-on selects programming
// - reserved bits written zero, read undefined
// - fixed-zero bits always read zero
// - fixed-one bits always read one; no bit is held at one here, flash status follows flash_status after reset
// - bit addressable registers allow single-bit access
// - flash control reads status, takes command byte
// - two-byte data pointer at 83H and 82H
`ifndef SFR_BANK_DEFS_VH
`define SFR_BANK_DEFS_VH
`define ADDR_PORT0 8'h80
`define ADDR_SP 8'h81
`define ADDR_DPL 8'h82
`define ADDR_DPH 8'h83
`define ADDR_P0MA 8'h84
`define ADDR_P0MB 8'h85
`define ADDR_KEYPAD_MASK 8'h86
`define ADDR_PWR 8'h87
`define ADDR_T0AUX 8'h8F
`define ADDR_PORT1 8'h90
`define ADDR_P1MA 8'h91
`define ADDR_P1MB 8'h92
`define ADDR_KBPAT 8'h93
`define ADDR_KBCTL 8'h94
`define ADDR_DIV 8'h95
`define ADDR_AUX 8'hA2
`define ADDR_IE0 8'hA8
`define ADDR_COMPARATOR1_CONTROL 8'hAC
`define ADDR_PORT3 8'hB0
`define ADDR_P3MA 8'hB1
`define ADDR_P3MB 8'hB2
`define ADDR_PWRA 8'hB5
`define ADDR_PWRB 8'hB6
`define ADDR_INTERRUPT_PRIORITY_0_HIGH 8'hB7
`define ADDR_IP0 8'hB8
`define ADDR_PSW 8'hD0
`define ADDR_RTCCTL 8'hD1
`define ADDR_RTC_RELOAD_HIGH 8'hD2
`define ADDR_RTC_RELOAD_LOW 8'hD3
`define ADDR_RESET_SOURCE 8'hDF
`define ADDR_ACC 8'hE0
`define ADDR_FLCTL 8'hE4
`define ADDR_FLDATA 8'hE5
`define ADDR_FLADRL 8'hE6
`define ADDR_FLADRH 8'hE7
`define ADDR_IE1 8'hE8
`define ADDR_B 8'hF0
`define ADDR_P0DID 8'hF6
`define ADDR_INTERRUPT_PRIORITY_1_HIGH 8'hF7
`define ADDR_IP1 8'hF8
`define ADDR_BITOP 8'hFC
`define RST_MODE_A 8'hFF
`define RST_P3MODE_A 8'h03
`define RST_SP 8'h07
`define RST_KBPAT 8'hFF
`define RST_RTCCTL 8'h60
`define RST_FLSTAT 8'h70
`define RST_ZERO 8'h00
`define RST_PORT 8'hFF
`define POR_SAMPLE 2'h2
`define MASK_KBCTL 8'h03
`define MASK_COMPARATOR1_CONTROL 8'h3D
`define MASK_AUX 8'hFB
`define MASK_PORT0_DIGITAL_INPUT_DISABLE 8'h3C
`define MASK_RTCCTL 8'hE3
`define MASK_IE1 8'h06
`define BIT_INPUT_ONLY 5
`endif

// *** logic/sfr_bank.v ***
// Decided for this implementation: strobed register access.
`include "sfr_bank_defs.vh"
`default_nettype none
module sfr_bank #(
	parameter W = 8
) (
	input wire clk,
	input wire rst,
	input wire [7:0] addr,
	input wire [W-1:0] wdata,
	input wire wr,
	input wire rd,
	output reg [W-1:0] rdata_ff,
	input wire [W-1:0] port0_in,
	input wire [W-1:0] port1_in,
	input wire [W-1:0] port3_in,
	output reg [W-1:0] port0_out_ff,
	output reg [W-1:0] port0_oe_n_ff,
	output reg [W-1:0] port0_pullup_ff,
	output reg [W-1:0] port1_out_ff,
	output reg [W-1:0] port1_oe_n_ff,
	output reg [W-1:0] port1_pullup_ff,
	output reg [W-1:0] port3_out_ff,
	output reg [W-1:0] port3_oe_n_ff,
	output reg [W-1:0] port3_pullup_ff,
	input wire [W-1:0] flash_status,
	output reg [W-1:0] flash_command_byte_ff,
	output reg flash_cmd_stb_ff,
	output reg [15:0] data_pointer_ff,
	output reg isp_entry_ff,
	output reg core_reset_ff
);
////////////////////////////////////////////////////////////
// pin synchronisers
reg [W-1:0] p0_s1_ff, p0_s2_ff, p1_s1_ff, p1_s2_ff, p3_s1_ff, p3_s2_ff;
reg [1:0] por_cnt_ff;
// pins idle high, so the synchronisers reset high
always @(posedge clk or posedge rst) begin
	if (rst) begin
		p0_s1_ff <= {W{1'b1}};
		p0_s2_ff <= {W{1'b1}};
		p1_s1_ff <= {W{1'b1}};
		p1_s2_ff <= {W{1'b1}};
		p3_s1_ff <= {W{1'b1}};
		p3_s2_ff <= {W{1'b1}};
	end else begin
		p0_s1_ff <= port0_in;
		p0_s2_ff <= p0_s1_ff;
		p1_s1_ff <= port1_in;
		p1_s2_ff <= p1_s1_ff;
		p3_s1_ff <= port3_in;
		p3_s2_ff <= p3_s1_ff;
	end
end
wire reset_pin_low = ~p1_s2_ff[`BIT_INPUT_ONLY];
////////////////////////////////////////////////////////////
// registers
reg [W-1:0] p0_ff, p1_ff, p3_ff, sp_ff, dpl_ff, dph_ff;
reg [W-1:0] p0ma_ff, p0mb_ff, p1ma_ff, p1mb_ff, p3ma_ff, p3mb_ff;
reg [W-1:0] keypad_mask_ff, pwr_ff, t0aux_ff, kbpat_ff, kbctl_ff, div_ff;
reg [W-1:0] aux_ff, ie0_ff, comparator1_control_ff, pwra_ff, interrupt_priority_0_high_ff, ip0_ff, psw_ff;
reg [W-1:0] rtcctl_ff, rtc_reload_high_ff, rtc_reload_low_ff, reset_source_ff, acc_ff;
reg [W-1:0] fldata_ff, fladrl_ff, fladrh_ff, ie1_ff, b_ff, p0did_ff;
reg [W-1:0] interrupt_priority_1_high_ff, ip1_ff, fstat_ff;
reg [W-1:0] nxt_rdata;
// single-bit write: FD holds the value, FC takes the bit address
wire bit_wr = wr && (addr == `ADDR_BITOP);
wire [7:0] bit_reg = {wdata[7:3], 3'h0};
wire [2:0] bit_num = wdata[2:0];
reg bit_val_ff;
wire sw_reset = core_reset_ff;
function [W-1:0] upd;
	input [W-1:0] cur;
	input [7:0] a;
	begin
		upd = cur;
		if (wr && addr == a)
			upd = wdata;
		else if (bit_wr && bit_reg == a)
			upd[bit_num] = bit_val_ff;
	end
endfunction
////////////////////////////////////////////////////////////
// bit value latch: a bit write takes the value from the last write to FD
always @(posedge clk or posedge rst) begin
	if (rst) begin
		bit_val_ff <= 1'b0;
	end else if (wr && addr == (`ADDR_BITOP + 8'h01)) begin
		bit_val_ff <= wdata[0];
	end
end
always @(posedge clk or posedge rst) begin
	if (rst) begin
		p0_ff <= `RST_PORT;
		p1_ff <= `RST_PORT;
		p3_ff <= `RST_PORT;
		sp_ff <= `RST_SP;
		dpl_ff <= `RST_ZERO;
		dph_ff <= `RST_ZERO;
		p0ma_ff <= `RST_MODE_A;
		p0mb_ff <= `RST_ZERO;
		p1ma_ff <= `RST_MODE_A;
		p1mb_ff <= `RST_ZERO;
		p3ma_ff <= `RST_P3MODE_A;
		p3mb_ff <= `RST_ZERO;
		keypad_mask_ff <= `RST_ZERO;
		pwr_ff <= `RST_ZERO;
		t0aux_ff <= `RST_ZERO;
		kbpat_ff <= `RST_KBPAT;
		kbctl_ff <= `RST_ZERO;
		div_ff <= `RST_ZERO;
		aux_ff <= `RST_ZERO;
		ie0_ff <= `RST_ZERO;
		comparator1_control_ff <= `RST_ZERO;
		pwra_ff <= `RST_ZERO;
		interrupt_priority_0_high_ff <= `RST_ZERO;
		ip0_ff <= `RST_ZERO;
		psw_ff <= `RST_ZERO;
		rtcctl_ff <= `RST_RTCCTL;
		rtc_reload_high_ff <= `RST_ZERO;
		rtc_reload_low_ff <= `RST_ZERO;
		acc_ff <= `RST_ZERO;
		fldata_ff <= `RST_ZERO;
		fladrl_ff <= `RST_ZERO;
		fladrh_ff <= `RST_ZERO;
		ie1_ff <= `RST_ZERO;
		b_ff <= `RST_ZERO;
		p0did_ff <= `RST_ZERO;
		interrupt_priority_1_high_ff <= `RST_ZERO;
		ip1_ff <= `RST_ZERO;
	end else if (sw_reset) begin
		p0_ff <= `RST_PORT;
		p1_ff <= `RST_PORT;
		p3_ff <= `RST_PORT;
		sp_ff <= `RST_SP;
		dpl_ff <= `RST_ZERO;
		dph_ff <= `RST_ZERO;
		p0ma_ff <= `RST_MODE_A;
		p0mb_ff <= `RST_ZERO;
		p1ma_ff <= `RST_MODE_A;
		p1mb_ff <= `RST_ZERO;
		p3ma_ff <= `RST_P3MODE_A;
		p3mb_ff <= `RST_ZERO;
		keypad_mask_ff <= `RST_ZERO;
		pwr_ff <= `RST_ZERO;
		t0aux_ff <= `RST_ZERO;
		kbpat_ff <= `RST_KBPAT;
		kbctl_ff <= `RST_ZERO;
		div_ff <= `RST_ZERO;
		aux_ff <= `RST_ZERO;
		ie0_ff <= `RST_ZERO;
		comparator1_control_ff <= `RST_ZERO;
		pwra_ff <= `RST_ZERO;
		interrupt_priority_0_high_ff <= `RST_ZERO;
		ip0_ff <= `RST_ZERO;
		psw_ff <= `RST_ZERO;
		rtcctl_ff <= `RST_RTCCTL;
		rtc_reload_high_ff <= `RST_ZERO;
		rtc_reload_low_ff <= `RST_ZERO;
		acc_ff <= `RST_ZERO;
		fldata_ff <= `RST_ZERO;
		fladrl_ff <= `RST_ZERO;
		fladrh_ff <= `RST_ZERO;
		ie1_ff <= `RST_ZERO;
		b_ff <= `RST_ZERO;
		p0did_ff <= `RST_ZERO;
		interrupt_priority_1_high_ff <= `RST_ZERO;
		ip1_ff <= `RST_ZERO;
	end else begin
		p0_ff <= upd(p0_ff, `ADDR_PORT0);
		p1_ff <= upd(p1_ff, `ADDR_PORT1);
		p3_ff <= upd(p3_ff, `ADDR_PORT3);
		sp_ff <= upd(sp_ff, `ADDR_SP);
		dpl_ff <= upd(dpl_ff, `ADDR_DPL);
		dph_ff <= upd(dph_ff, `ADDR_DPH);
		p0ma_ff <= upd(p0ma_ff, `ADDR_P0MA);
		p0mb_ff <= upd(p0mb_ff, `ADDR_P0MB);
		p1ma_ff <= upd(p1ma_ff, `ADDR_P1MA);
		p1mb_ff <= upd(p1mb_ff, `ADDR_P1MB);
		p3ma_ff <= upd(p3ma_ff, `ADDR_P3MA);
		p3mb_ff <= upd(p3mb_ff, `ADDR_P3MB);
		keypad_mask_ff <= upd(keypad_mask_ff, `ADDR_KEYPAD_MASK);
		pwr_ff <= upd(pwr_ff, `ADDR_PWR);
		t0aux_ff <= upd(t0aux_ff, `ADDR_T0AUX);
		kbpat_ff <= upd(kbpat_ff, `ADDR_KBPAT);
		kbctl_ff <= upd(kbctl_ff, `ADDR_KBCTL) & `MASK_KBCTL;
		div_ff <= upd(div_ff, `ADDR_DIV);
		aux_ff <= upd(aux_ff, `ADDR_AUX) & `MASK_AUX;
		ie0_ff <= upd(ie0_ff, `ADDR_IE0);
		comparator1_control_ff <= upd(comparator1_control_ff, `ADDR_COMPARATOR1_CONTROL) & `MASK_COMPARATOR1_CONTROL;
		pwra_ff <= upd(pwra_ff, `ADDR_PWRA);
		interrupt_priority_0_high_ff <= upd(interrupt_priority_0_high_ff, `ADDR_INTERRUPT_PRIORITY_0_HIGH);
		ip0_ff <= upd(ip0_ff, `ADDR_IP0);
		psw_ff <= upd(psw_ff, `ADDR_PSW);
		rtcctl_ff <= upd(rtcctl_ff, `ADDR_RTCCTL) & `MASK_RTCCTL;
		rtc_reload_high_ff <= upd(rtc_reload_high_ff, `ADDR_RTC_RELOAD_HIGH);
		rtc_reload_low_ff <= upd(rtc_reload_low_ff, `ADDR_RTC_RELOAD_LOW);
		acc_ff <= upd(acc_ff, `ADDR_ACC);
		fldata_ff <= upd(fldata_ff, `ADDR_FLDATA);
		fladrl_ff <= upd(fladrl_ff, `ADDR_FLADRL);
		fladrh_ff <= upd(fladrh_ff, `ADDR_FLADRH);
		ie1_ff <= upd(ie1_ff, `ADDR_IE1) & `MASK_IE1;
		b_ff <= upd(b_ff, `ADDR_B);
		p0did_ff <= upd(p0did_ff, `ADDR_P0DID) & `MASK_PORT0_DIGITAL_INPUT_DISABLE;
		interrupt_priority_1_high_ff <= upd(interrupt_priority_1_high_ff, `ADDR_INTERRUPT_PRIORITY_1_HIGH);
		ip1_ff <= upd(ip1_ff, `ADDR_IP1);
	end
end
////////////////////////////////////////////////////////////
// flash control: status on read, command byte on write
// status is registered so a read sees a settled value
always @(posedge clk or posedge rst) begin
	if (rst) begin
		fstat_ff <= `RST_FLSTAT;
		flash_command_byte_ff <= `RST_ZERO;
		flash_cmd_stb_ff <= 1'b0;
	end else begin
		fstat_ff <= core_reset_ff ? `RST_FLSTAT : flash_status;
		flash_cmd_stb_ff <= wr && addr == `ADDR_FLCTL;
		if (wr && addr == `ADDR_FLCTL)
			flash_command_byte_ff <= wdata;
	end
end
////////////////////////////////////////////////////////////
// reset pin, software reset and programming entry
reg pin_low_d_ff;
always @(posedge clk or posedge rst) begin
	if (rst) begin
		por_cnt_ff <= 2'h0;
		isp_entry_ff <= 1'b0;
		core_reset_ff <= 1'b0;
		pin_low_d_ff <= 1'b0;
	end else begin
		pin_low_d_ff <= reset_pin_low;
		if (por_cnt_ff != 2'h3)
			por_cnt_ff <= por_cnt_ff + 2'h1;
		// the synchroniser shows the real pin level from the third edge on
		if (por_cnt_ff == `POR_SAMPLE)
			isp_entry_ff <= reset_pin_low;
		core_reset_ff <= (reset_pin_low && pin_low_d_ff) || (wr && addr == `ADDR_AUX && wdata[3]);
	end
end
// reset cause: pin or software; writing zero clears a flag
always @(posedge clk or posedge rst) begin
	if (rst) begin
		reset_source_ff <= `RST_ZERO;
	end else begin
		if (core_reset_ff && reset_pin_low)
			reset_source_ff <= 8'h01;
		else if (core_reset_ff)
			reset_source_ff <= 8'h02;
		else if (wr && addr == `ADDR_RESET_SOURCE)
			reset_source_ff <= reset_source_ff & wdata;
	end
end
////////////////////////////////////////////////////////////
// pin drivers: mode a/b per pin, 00 quasi, 01 push-pull, 10 input, 11 open drain
integer i;
reg [W-1:0] nxt_p0_oe_n, nxt_p1_oe_n, nxt_p3_oe_n;
reg [W-1:0] nxt_p0_pu, nxt_p1_pu, nxt_p3_pu;
// 00 and 11 drive only a low latch, 01 always drives, 10 never drives
always @* begin
	nxt_p0_oe_n = {W{1'b1}};
	nxt_p1_oe_n = {W{1'b1}};
	nxt_p3_oe_n = {W{1'b1}};
	nxt_p0_pu = {W{1'b0}};
	nxt_p1_pu = {W{1'b0}};
	nxt_p3_pu = {W{1'b0}};
	for (i = 0; i < W; i = i + 1) begin
		nxt_p0_oe_n[i] = (p0ma_ff[i] & ~p0mb_ff[i]) | (~(p0ma_ff[i] ^ p0mb_ff[i]) & p0_ff[i]);
		nxt_p1_oe_n[i] = (p1ma_ff[i] & ~p1mb_ff[i]) | (~(p1ma_ff[i] ^ p1mb_ff[i]) & p1_ff[i]);
		nxt_p3_oe_n[i] = (p3ma_ff[i] & ~p3mb_ff[i]) | (~(p3ma_ff[i] ^ p3mb_ff[i]) & p3_ff[i]);
		nxt_p0_pu[i] = ~p0ma_ff[i] & ~p0mb_ff[i];
		nxt_p1_pu[i] = ~p1ma_ff[i] & ~p1mb_ff[i];
		nxt_p3_pu[i] = ~p3ma_ff[i] & ~p3mb_ff[i];
	end
	nxt_p1_oe_n[`BIT_INPUT_ONLY] = 1'b1;
	nxt_p1_pu[`BIT_INPUT_ONLY] = 1'b0;
end
// core reset turns every pin to input at once
always @(posedge clk or posedge rst) begin
	if (rst) begin
		port0_out_ff <= {W{1'b1}};
		port0_oe_n_ff <= {W{1'b1}};
		port0_pullup_ff <= {W{1'b0}};
		port1_out_ff <= {W{1'b1}};
		port1_oe_n_ff <= {W{1'b1}};
		port1_pullup_ff <= {W{1'b0}};
		port3_out_ff <= {W{1'b1}};
		port3_oe_n_ff <= {W{1'b1}};
		port3_pullup_ff <= {W{1'b0}};
		data_pointer_ff <= 16'h0000;
	end else if (sw_reset) begin
		port0_out_ff <= {W{1'b1}};
		port0_oe_n_ff <= {W{1'b1}};
		port0_pullup_ff <= {W{1'b0}};
		port1_out_ff <= {W{1'b1}};
		port1_oe_n_ff <= {W{1'b1}};
		port1_pullup_ff <= {W{1'b0}};
		port3_out_ff <= {W{1'b1}};
		port3_oe_n_ff <= {W{1'b1}};
		port3_pullup_ff <= {W{1'b0}};
		data_pointer_ff <= 16'h0000;
	end else begin
		port0_out_ff <= p0_ff;
		port0_oe_n_ff <= nxt_p0_oe_n;
		port0_pullup_ff <= nxt_p0_pu;
		port1_out_ff <= p1_ff;
		port1_oe_n_ff <= nxt_p1_oe_n;
		port1_pullup_ff <= nxt_p1_pu;
		port3_out_ff <= p3_ff;
		port3_oe_n_ff <= nxt_p3_oe_n;
		port3_pullup_ff <= nxt_p3_pu;
		data_pointer_ff <= {dph_ff, dpl_ff};
	end
end
////////////////////////////////////////////////////////////
// read path; undefined addresses read zero
always @* begin
	case (addr)
	`ADDR_PORT0: nxt_rdata = p0_s2_ff;
	`ADDR_SP: nxt_rdata = sp_ff;
	`ADDR_DPL: nxt_rdata = dpl_ff;
	`ADDR_DPH: nxt_rdata = dph_ff;
	`ADDR_P0MA: nxt_rdata = p0ma_ff;
	`ADDR_P0MB: nxt_rdata = p0mb_ff;
	`ADDR_KEYPAD_MASK: nxt_rdata = keypad_mask_ff;
	`ADDR_PWR: nxt_rdata = pwr_ff;
	`ADDR_T0AUX: nxt_rdata = t0aux_ff;
	`ADDR_PORT1: nxt_rdata = p1_s2_ff;
	`ADDR_P1MA: nxt_rdata = p1ma_ff;
	`ADDR_P1MB: nxt_rdata = p1mb_ff;
	`ADDR_KBPAT: nxt_rdata = kbpat_ff;
	`ADDR_KBCTL: nxt_rdata = kbctl_ff;
	`ADDR_DIV: nxt_rdata = div_ff;
	`ADDR_AUX: nxt_rdata = aux_ff & `MASK_AUX;
	`ADDR_IE0: nxt_rdata = ie0_ff;
	`ADDR_COMPARATOR1_CONTROL: nxt_rdata = comparator1_control_ff;
	`ADDR_PORT3: nxt_rdata = p3_s2_ff;
	`ADDR_P3MA: nxt_rdata = p3ma_ff;
	`ADDR_P3MB: nxt_rdata = p3mb_ff;
	`ADDR_PWRA: nxt_rdata = pwra_ff;
	`ADDR_PWRB: nxt_rdata = `RST_ZERO;
	`ADDR_INTERRUPT_PRIORITY_0_HIGH: nxt_rdata = interrupt_priority_0_high_ff;
	`ADDR_IP0: nxt_rdata = ip0_ff;
	`ADDR_PSW: nxt_rdata = psw_ff;
	`ADDR_RTCCTL: nxt_rdata = rtcctl_ff;
	`ADDR_RTC_RELOAD_HIGH: nxt_rdata = rtc_reload_high_ff;
	`ADDR_RTC_RELOAD_LOW: nxt_rdata = rtc_reload_low_ff;
	`ADDR_RESET_SOURCE: nxt_rdata = reset_source_ff;
	`ADDR_ACC: nxt_rdata = acc_ff;
	`ADDR_FLCTL: nxt_rdata = fstat_ff;
	`ADDR_FLDATA: nxt_rdata = fldata_ff;
	`ADDR_FLADRL: nxt_rdata = fladrl_ff;
	`ADDR_FLADRH: nxt_rdata = fladrh_ff;
	`ADDR_IE1: nxt_rdata = ie1_ff;
	`ADDR_B: nxt_rdata = b_ff;
	`ADDR_P0DID: nxt_rdata = p0did_ff;
	`ADDR_INTERRUPT_PRIORITY_1_HIGH: nxt_rdata = interrupt_priority_1_high_ff;
	`ADDR_IP1: nxt_rdata = ip1_ff;
	default: nxt_rdata = `RST_ZERO;
	endcase
end
always @(posedge clk or posedge rst) begin
	if (rst) begin
		rdata_ff <= `RST_ZERO;
	end else if (rd) begin
		rdata_ff <= nxt_rdata;
	end else begin
		rdata_ff <= `RST_ZERO;
	end
end
endmodule
`default_nettype wire

// *** tb/sfr_bank_assertions.sv ***
`default_nettype none
module sfr_bank_checker (
	input wire logic clk,
	input wire logic rst,
	input wire logic [7:0] addr,
	input wire logic [7:0] wdata,
	input wire logic wr,
	input wire logic rd,
	input wire logic [7:0] rdata_ff,
	input wire logic [7:0] port1_in,
	input wire logic [7:0] port0_oe_n_ff,
	input wire logic [7:0] port0_pullup_ff,
	input wire logic [7:0] port1_oe_n_ff,
	input wire logic [7:0] port1_pullup_ff,
	input wire logic [7:0] flash_command_byte_ff,
	input wire logic flash_cmd_stb_ff,
	input wire logic [15:0] data_pointer_ff,
	input wire logic isp_entry_ff,
	input wire logic core_reset_ff
);
	timeunit 1ns;
	timeprecision 100ps;
	logic [2:0] age_ff;
	logic [2:0] nxt_age;
	assign nxt_age = (age_ff == 3'h7) ? age_ff : age_ff + 3'h1;
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			age_ff <= 3'h0;
		end else begin
			age_ff <= nxt_age;
		end
	end
	default clocking @(posedge clk); endclocking
	default disable iff (rst);
	sequence dp_lo_wr;
		wr && addr == 8'h82 ##1 !(wr && addr == 8'h82);
	endsequence
	chk_reset_input_only: assert property ($fell(rst) |->
		port0_oe_n_ff == 8'hFF && port1_oe_n_ff == 8'hFF && port0_pullup_ff == 8'h00
		&& port1_pullup_ff == 8'h00) else $error("ports not input only after reset");
	chk_pin5_no_drive: assert property (port1_oe_n_ff[5])
		else $error("input only pin driven");
	chk_flash_cmd_take: assert property (wr && addr == 8'hE4 |=>
		flash_cmd_stb_ff && flash_command_byte_ff == $past(wdata)) else $error("flash command lost");
	chk_flash_stb_cause: assert property (flash_cmd_stb_ff |->
		$past(wr) && $past(addr) == 8'hE4) else $error("stray flash strobe");
	chk_dptr_low_byte: assert property (dp_lo_wr |-> ##1
		data_pointer_ff[7:0] == $past(wdata, 2)) else $error("pointer low byte wrong");
	chk_fixed_zero_bit: assert property (rd && addr == 8'hA2 |=> !rdata_ff[2])
		else $error("fixed zero bit read one");
	chk_core_reset_ports: assert property (core_reset_ff |-> ##[1:2]
		port0_oe_n_ff == 8'hFF && port0_pullup_ff == 8'h00) else $error("ports kept after reset");
	chk_pin_reset_fires: assert property (!port1_in[5] [*5] |-> ##[0:3] core_reset_ff)
		else $error("pin reset missed");
	chk_isp_held: assert property (age_ff == 3'h7 |-> $stable(isp_entry_ff))
		else $error("programming entry changed");
endmodule
bind sfr_bank sfr_bank_checker chk_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata),
	.wr(wr), .rd(rd), .rdata_ff(rdata_ff), .port1_in(port1_in),
	.port0_oe_n_ff(port0_oe_n_ff), .port0_pullup_ff(port0_pullup_ff),
	.port1_oe_n_ff(port1_oe_n_ff), .port1_pullup_ff(port1_pullup_ff),
	.flash_command_byte_ff(flash_command_byte_ff), .flash_cmd_stb_ff(flash_cmd_stb_ff),
	.data_pointer_ff(data_pointer_ff), .isp_entry_ff(isp_entry_ff),
	.core_reset_ff(core_reset_ff));
`default_nettype wire

// *** tb/tb.sv ***
`default_nettype none
module tb;
	timeunit 1ns;
	timeprecision 100ps;
	logic clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] addr = 8'h00, wdata = 8'h00, p0 = 8'hFF, p1 = 8'hFF, p3 = 8'hFF;
	logic wr = 1'b0, rd = 1'b0;
	logic [7:0] fstat = 8'h70;
	logic [7:0] rdata, o0, e0, u0, o1, e1, u1, o3, e3, u3, fcmd;
	logic fstb, isp, crst;
	logic [15:0] dptr;
	int errors = 0, n_checks = 0;
	always #2.5 clk = ~clk;
	sfr_bank dut_u (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata_ff(rdata), .port0_in(p0), .port1_in(p1), .port3_in(p3),
		.port0_out_ff(o0), .port0_oe_n_ff(e0), .port0_pullup_ff(u0),
		.port1_out_ff(o1), .port1_oe_n_ff(e1), .port1_pullup_ff(u1),
		.port3_out_ff(o3), .port3_oe_n_ff(e3), .port3_pullup_ff(u3),
		.flash_status(fstat), .flash_command_byte_ff(fcmd), .flash_cmd_stb_ff(fstb),
		.data_pointer_ff(dptr), .isp_entry_ff(isp), .core_reset_ff(crst));
	////////////////////////////////////////////////////////////////
	task automatic chk(input logic [15:0] got, input logic [15:0] exp);
		n_checks++;
		if (got !== exp) begin
			errors++;
			$display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask
	task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		chk(rdata, exp);
	endtask
	task automatic tally_and_finish;
		$display("checks %0d errors %0d", n_checks, errors);
		if (errors == 0 && n_checks > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_reset;
		logic [7:0] ra [7] = '{8'h81, 8'h84, 8'hB1, 8'h93, 8'hD1, 8'hE4, 8'h83};
		logic [7:0] rv [7] = '{8'h07, 8'hFF, 8'h03, 8'hFF, 8'h60, 8'h70, 8'h00};
		chk({e1, e0}, 16'hFFFF);
		chk({u1, u0}, 16'h0000);
		chk(isp, 1'b0);
		chk({o1, o0}, 16'hFFFF);
		chk({o3, e3}, 16'hFFFF);
		for (int i = 0; i < 7; i++) rd_chk(ra[i], rv[i]);
	endtask
	task automatic t_modes;
		wr_reg(8'h91, 8'h00);
		wr_reg(8'h92, 8'hFF);
		wr_reg(8'h84, 8'hFE);
		wr_reg(8'h85, 8'h01);
		wr_reg(8'hB1, 8'hFF);
		wr_reg(8'hB2, 8'h03);
		wr_reg(8'hB0, 8'h02);
		repeat (2) @(posedge clk);
		#1;
		chk(e1, 8'h20);
		chk(e0, 8'hFE);
		chk(e3, 8'hFE);
		chk(u3, 8'h00);
	endtask
	task automatic t_dptr_flash;
		wr_reg(8'h83, 8'hA5);
		wr_reg(8'h82, 8'h3C);
		repeat (2) @(posedge clk);
		#1;
		chk(dptr, 16'hA53C);
		fstat <= 8'h81;
		wr_reg(8'hE4, 8'h5A);
		#1;
		chk({fstb, fcmd}, 16'h015A);
		rd_chk(8'hE4, 8'h81);
	endtask
	task automatic t_bits;
		wr_reg(8'hA2, 8'hF1);
		rd_chk(8'hA2, 8'hF1);
		rd_chk(8'h89, 8'h00);
		wr_reg(8'hE0, 8'h00);
		wr_reg(8'hFD, 8'h01);
		wr_reg(8'hFC, 8'hE3);
		wr_reg(8'hFD, 8'h01);
		wr_reg(8'hFC, 8'hE7);
		rd_chk(8'hE0, 8'h88);
	endtask
	task automatic t_pin_reset;
		wr_reg(8'hE0, 8'h55);
		p1 <= 8'hDF;
		repeat (8) @(posedge clk);
		p1 <= 8'hFF;
		repeat (6) @(posedge clk);
		rd_chk(8'hE0, 8'h00);
		rd_chk(8'h91, 8'hFF);
		chk(e1, 8'hFF);
	endtask
	task automatic t_isp;
		@(posedge clk);
		rst <= 1'b1;
		p1 <= 8'hDF;
		repeat (3) @(posedge clk);
		rst <= 1'b0;
		repeat (3) @(posedge clk);
		p1 <= 8'hFF;
		repeat (8) @(posedge clk);
		#1;
		chk(isp, 1'b1);
	endtask
	////////////////////////////////////////////////////////////////
	initial begin
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		t_reset();
		t_modes();
		t_dptr_flash();
		t_bits();
		t_pin_reset();
		t_isp();
		tally_and_finish();
	end
	initial begin
		#20000;
		errors++;
		tally_and_finish();
	end
endmodule
`default_nettype wire
